// file: rtl/pwmtg_top.sv
`timescale 1ns/1ns
// Summary of operation
// - Start level chooses duty as on or off
// - Select bit routes byte ports period/duty
// - Clock select: microsecond tick or system clock
// - Mode field: off, PWM, square, staircase
// - Low port accesses selected low byte
// - High port accesses selected high byte
// - Divisor sets tone half period length
// - Staircase floats last quarter of half period
module pwmtg_top (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Generator pin
	output logic gen_out,
	output logic gen_oe
);
	import pwmtg_pkg::*;

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [7:0] control_q, control_d;
	logic [15:0] period_q, period_d;
	logic [15:0] duty_q, duty_d;
	logic [7:0] rdata_q, rdata_d;
	logic start_level;
	logic reg_select;
	logic clock_select;
	logic [2:0] generator_mode_field;
	logic [15:0] selected_value;

	assign start_level = control_q[PWMTG_BIT_START_LEVEL];
	assign reg_select = control_q[PWMTG_BIT_REG_SELECT];
	assign clock_select = control_q[PWMTG_BIT_CLOCK_SELECT];
	assign generator_mode_field = control_q[PWMTG_MODE_MSB:0];
	// Byte ports see whichever 16-bit register is selected
	assign selected_value = reg_select ? duty_q : period_q;

	// Write decode and read mux; unmapped reads return zero.
	// Each byte lands on its own, so software that changes a running
	// period byte by byte sees one mixed value for a short while.
	always_comb begin
		control_d = control_q;
		period_d = period_q;
		duty_d = duty_q;
		rdata_d = 8'h00;
		if (reg_wr) begin
			case (reg_addr)
				PWMTG_ADDR_CONTROL: begin
					control_d = reg_wdata & PWMTG_CONTROL_MASK;
				end
				PWMTG_ADDR_LOW: begin
					if (reg_select) duty_d[7:0] = reg_wdata;
					else period_d[7:0] = reg_wdata;
				end
				PWMTG_ADDR_HIGH: begin
					if (reg_select) duty_d[15:8] = reg_wdata;
					else period_d[15:8] = reg_wdata;
				end
				default: begin
				end
			endcase
		end
		// Read data stands one cycle only and is zero otherwise
		if (reg_rd) begin
			case (reg_addr)
				PWMTG_ADDR_CONTROL: rdata_d = control_q;
				PWMTG_ADDR_LOW: rdata_d = selected_value[7:0];
				PWMTG_ADDR_HIGH: rdata_d = selected_value[15:8];
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// Register file; reset returns the generator to its disabled mode
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			control_q <= PWMTG_CONTROL_RESET;
			period_q <= PWMTG_COUNT_RESET;
			duty_q <= PWMTG_COUNT_RESET;
			rdata_q <= 8'h00;
		end else begin
			control_q <= control_d;
			period_q <= period_d;
			duty_q <= duty_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// ----------------------------------------------------------------
	// Count clock
	// ----------------------------------------------------------------
	logic microsecond_clock_tick;
	logic count_en;

	pwmtg_microsecond_clock_divider u_microsecond_clock (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.microsecond_clock_tick(microsecond_clock_tick)
	);

	// System clock counts every cycle, otherwise once per microsecond.
	// The tick runs free, so the first count after switching to it may
	// be short; keeping one divider saves a restart path on every
	// mode change.
	assign count_en = clock_select ? 1'b1 : microsecond_clock_tick;

	// ----------------------------------------------------------------
	// Waveform generator
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PWMTG_ST_IDLE,
		PWMTG_ST_PWM,
		PWMTG_ST_TONE
	} pwmtg_state_t;

	pwmtg_state_t state_q, state_d;
	logic [15:0] count_q, count_d;
	logic tone_q, tone_d;
	logic out_q, out_d;
	logic oe_q, oe_d;
	logic [15:0] float_from;
	logic [15:0] tone_last;
	logic tone_wrap;

	// Divisor is the period register while tones run: software keeps
	// the select bit clear then, duty is never used as divisor.
	// A half period is exactly divisor counts, so the count runs from
	// zero to one below the divisor. A zero divisor is taken as one
	// count rather than letting the subtraction wrap.
	assign tone_last = (period_q == 16'h0000) ? 16'h0000
		: period_q - 16'h0001;
	assign tone_wrap = (count_q >= tone_last);
	// Last quarter of the half period floats; the quarter rounds down,
	// so divisors from one to three never float at all
	assign float_from = period_q - {2'b00, period_q[15:2]};

	// Next-state and pin logic; the pins are registered so a count
	// compare can never glitch them
	always_comb begin
		state_d = state_q;
		count_d = count_q;
		tone_d = tone_q;
		out_d = 1'b0;
		oe_d = 1'b0;
		case (generator_mode_field)
			PWMTG_MODE_PWM: state_d = PWMTG_ST_PWM;
			PWMTG_MODE_SQUARE, PWMTG_MODE_STAIR: state_d = PWMTG_ST_TONE;
			default: state_d = PWMTG_ST_IDLE;
		endcase
		// A change of state restarts the waveform from a clean count; square to staircase keeps counting
		if (state_d != state_q) begin
			count_d = 16'h0000;
			tone_d = 1'b0;
		end
		case (state_q)
			PWMTG_ST_PWM: begin
				// Below duty drives the inverted start level, rest the start level
				oe_d = 1'b1;
				out_d = (count_q < duty_q) ? ~start_level
					: start_level;
				if (count_en && state_d == state_q) begin
					if (count_q >= period_q) count_d = 16'h0000;
					else count_d = count_q + 16'h0001;
				end
			end
			PWMTG_ST_TONE: begin
				out_d = tone_q;
				oe_d = 1'b1;
				if (generator_mode_field == PWMTG_MODE_STAIR &&
					count_q >= float_from) begin
					oe_d = 1'b0;
				end
				if (count_en && state_d == state_q) begin
					if (tone_wrap) begin
						count_d = 16'h0000;
						tone_d = ~tone_q;
					end else begin
						count_d = count_q + 16'h0001;
					end
				end
			end
			default: begin
				out_d = 1'b0;
				oe_d = 1'b0;
			end
		endcase
	end

	// Generator state; reset leaves the pin released and low
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_q <= PWMTG_ST_IDLE;
			count_q <= 16'h0000;
			tone_q <= 1'b0;
			out_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			state_q <= state_d;
			count_q <= count_d;
			tone_q <= tone_d;
			out_q <= out_d;
			oe_q <= oe_d;
		end
	end

	// Pins come straight from flip-flops
	assign gen_out = out_q;
	assign gen_oe = oe_q;
endmodule : pwmtg_top

// file: rtl/pwmtg_pkg.sv
package pwmtg_pkg;
	// ----------------------------------------------------------------
	// Register map and field layout
	// ----------------------------------------------------------------
	localparam logic [7:0] PWMTG_ADDR_CONTROL = 8'ha1;
	localparam logic [7:0] PWMTG_ADDR_LOW = 8'ha2;
	localparam logic [7:0] PWMTG_ADDR_HIGH = 8'ha3;
	localparam logic [7:0] PWMTG_CONTROL_RESET = 8'h00;
	localparam logic [15:0] PWMTG_COUNT_RESET = 16'h0000;
	localparam int PWMTG_BIT_START_LEVEL = 5;
	localparam int PWMTG_BIT_REG_SELECT = 4;
	localparam int PWMTG_BIT_CLOCK_SELECT = 3;
	localparam int PWMTG_MODE_MSB = 2;
	localparam logic [7:0] PWMTG_CONTROL_MASK = 8'h3f;
	// Mode field encodings
	localparam logic [2:0] PWMTG_MODE_OFF = 3'h0;
	localparam logic [2:0] PWMTG_MODE_PWM = 3'h1;
	localparam logic [2:0] PWMTG_MODE_SQUARE = 3'h2;
	localparam logic [2:0] PWMTG_MODE_STAIR = 3'h7;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int PWMTG_SYS_CLK_HZ = 20000000;
	localparam int PWMTG_MICROSECOND_CLOCK_HZ = 1000000;
	localparam int PWMTG_MICROSECOND_CLOCK_CYCLES = PWMTG_SYS_CLK_HZ / PWMTG_MICROSECOND_CLOCK_HZ;
	localparam logic [4:0] PWMTG_MICROSECOND_CLOCK_LAST = 5'(PWMTG_MICROSECOND_CLOCK_CYCLES - 1);
endpackage : pwmtg_pkg

// file: rtl/pwmtg_microsecond_clock_divider.sv
`timescale 1ns/1ns
// Microsecond tick: one-cycle enable pulse every PWMTG_MICROSECOND_CLOCK_CYCLES cycles
module pwmtg_microsecond_clock_divider (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Tick out
	output logic microsecond_clock_tick
);
	import pwmtg_pkg::*;

	logic [4:0] div_q;
	logic [4:0] div_d;
	logic tick_q;
	logic tick_d;

	// Free-running count, wraps on the last cycle of each microsecond
	always_comb begin
		tick_d = (div_q == PWMTG_MICROSECOND_CLOCK_LAST);
		div_d = tick_d ? 5'h00 : div_q + 5'h01;
	end

	// Registered tick, so the enable has no combinational path
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			div_q <= 5'h00;
			tick_q <= 1'b0;
		end else begin
			div_q <= div_d;
			tick_q <= tick_d;
		end
	end

	assign microsecond_clock_tick = tick_q;
endmodule : pwmtg_microsecond_clock_divider

// file: test/pwmtg_top_asserts.sv
`timescale 1ns/1ns
// ----
// Port checks
// ----
module pwmtg_top_asserts (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Pin
	input wire logic gen_out,
	input wire logic gen_oe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// Read data lives one cycle only, so a stale value never leaks
	property p_quiet; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
	a_quiet: assert property (p_quiet) else $error("rdata leak");
	property p_unmap;
		reg_rd && !(reg_addr inside {8'ha1, 8'ha2, 8'ha3}) |=> reg_rdata == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_ctl;
		reg_wr && reg_addr == 8'ha1 ##1 reg_rd && reg_addr == 8'ha1
		|=> reg_rdata == ($past(reg_wdata, 2) & 8'h3f);
	endproperty
	a_ctl: assert property (p_ctl) else $error("control readback");
	property p_low;
		reg_wr && reg_addr == 8'ha2 ##1 reg_rd && reg_addr == 8'ha2
		|=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_low: assert property (p_low) else $error("low readback");
	property p_high;
		reg_wr && reg_addr == 8'ha3 ##1 reg_rd && reg_addr == 8'ha3
		|=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_high: assert property (p_high) else $error("high readback");
	// Mode change reaches the pin within three edges
	property p_off;
		reg_wr && reg_addr == 8'ha1 && reg_wdata[2:0] == 3'h0
		|-> ##3 !gen_oe && !gen_out;
	endproperty
	a_off: assert property (p_off) else $error("off drives");
	property p_on;
		reg_wr && reg_addr == 8'ha1 && reg_wdata[2:0] inside {3'h1, 3'h2}
		|-> ##3 gen_oe;
	endproperty
	a_on: assert property (p_on) else $error("mode not driving");
	property p_rst;
		$past(sys_rst) |-> !gen_oe && !gen_out && reg_rdata == 8'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	c_pwm: cover property (reg_wr && reg_addr == 8'ha1 && reg_wdata == 8'h09);
	c_float: cover property ($fell(gen_oe));
	c_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule : pwmtg_top_asserts
bind pwmtg_top pwmtg_top_asserts u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .gen_out(gen_out),
	.gen_oe(gen_oe));

// file: test/pwmtg_top_bench.sv
`timescale 1ns/1ns
// ----
// Bench
// ----
module pwmtg_top_bench;
	logic sys_clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic gen_out, gen_oe, po;
	logic [7:0] pc [3] = '{8'h09, 8'h29, 8'h01};
	int pn [3] = '{100, 100, 400};
	int ph [3] = '{30, 70, 120};
	int miscompares = 0, checked = 0, hi, oe, tg;
	always #25 sys_clk = ~sys_clk;
	pwmtg_top DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .gen_out(gen_out), .gen_oe(gen_oe));
	// Compare and count
	task chk(input string n, input logic [31:0] g, e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s exp %0h got %0h", n, e, g);
		end
	endtask : chk
	// Bus tasks are entered right after a rising edge
	task wr(input logic [7:0] a, d);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
		@(posedge sys_clk);
	endtask : wr
	// Read data is taken mid-cycle, while it stands
	task rd(input logic [7:0] a, e);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		@(negedge sys_clk);
		chk("rdata", {24'h0, reg_rdata}, {24'h0, e});
		@(posedge sys_clk);
	endtask : rd
	// Write, then read back with no gap between the strobes
	task wrrd(input logic [7:0] a, d, e);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
		rd(a, e);
	endtask : wrrd
	// Counts pin levels over whole periods, so phase does not matter
	task win(input int n);
		hi = 0;
		oe = 0;
		tg = 0;
		@(negedge sys_clk);
		po = gen_out;
		repeat (n) begin
			@(negedge sys_clk);
			hi += gen_out;
			oe += gen_oe;
			tg += int'(gen_out != po);
			po = gen_out;
		end
		@(posedge sys_clk);
	endtask : win
	task give_verdict;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'h0;
		@(posedge sys_clk);
		rd(8'ha1, 8'h00);
		rd(8'ha3, 8'h00);
		wr(8'ha4, 8'hff);
		rd(8'ha4, 8'h00);
		$display("test reset done");
		wrrd(8'ha1, 8'hff, 8'h3f);
		wr(8'ha1, 8'h00);
		wr(8'ha2, 8'h09);
		wr(8'ha3, 8'h12);
		wr(8'ha1, 8'h10);
		wrrd(8'ha2, 8'h03, 8'h03);
		wrrd(8'ha3, 8'h00, 8'h00);
		wr(8'ha1, 8'h00);
		rd(8'ha3, 8'h12);
		wrrd(8'ha3, 8'h00, 8'h00);
		$display("test ports done");
		foreach (pc[i]) begin
			wr(8'ha1, pc[i]);
			repeat (5) @(posedge sys_clk);
			win(pn[i]);
			chk("pwm high", hi, ph[i]);
		end
		$display("test pwm done");
		wr(8'ha2, 8'h02);
		wr(8'ha1, 8'h0a);
		repeat (5) @(posedge sys_clk);
		win(60);
		chk("tone high", hi, 30);
		chk("tone edges", tg, 30);
		wr(8'ha2, 8'h08);
		wr(8'ha1, 8'h0f);
		repeat (5) @(posedge sys_clk);
		win(96);
		chk("stair oe", oe, 72);
		$display("test tone done");
		wr(8'ha1, 8'h0b);
		repeat (5) @(posedge sys_clk);
		win(20);
		chk("other oe", oe, 0);
		wr(8'ha1, 8'h08);
		repeat (5) @(posedge sys_clk);
		win(20);
		chk("off out", hi + oe, 0);
		$display("test off done");
		give_verdict();
	end
endmodule : pwmtg_top_bench
